// >>> rtl/eight_bit_bidir_port.sv
// eight-bit bidirectional port with avalon-mm register access
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Summary of operation
// - direction bit clear is output, set input
// - output mode field: hiz, pch, nch, push-pull
// - input mode field: hiz, pull-down, pull-up, hiz
// - mode low bit ctrl0, high bit ctrl1
// - reset clears direction and both control registers
// - push-pull output pins follow data register bits
// - input pins read back their pad level
// - segment select hands pins to segment driver
// - halfword at ctrl0 reaches both control bytes
// - output pins read back last written data
module eight_bit_bidir_port #(
  parameter int PINS = port_pkg::PIN_COUNT  // number of port pins
) (
  input  wire logic                            sys_clk,
  input  wire logic                            reset,
  input  wire logic [port_pkg::BUS_ADDR_W-1:0] avs_address,
  input  wire logic                            avs_read,
  input  wire logic                            avs_write,
  input  wire logic [port_pkg::BUS_DATA_W-1:0] avs_writedata,
  input  wire logic [3:0]                      avs_byteenable,
  output logic      [port_pkg::BUS_DATA_W-1:0] avs_readdata,
  output logic                                 avs_waitrequest,
  input  wire logic [PINS-1:0]                 pad_in,
  input  wire logic [PINS-1:0]                 seg_drive,
  output logic      [PINS-1:0]                 pad_out,
  output logic      [PINS-1:0]                 pad_oe,
  output logic      [PINS-1:0]                 pull_up_en,
  output logic      [PINS-1:0]                 pull_down_en
);

  // software visible registers
  logic [PINS-1:0] pin_level_data_r;           // output levels
  logic [PINS-1:0] pin_direction_select_r;     // per-pin direction
  logic [PINS-1:0] pin_mode_low_bits_r;        // mode field low bits
  logic [PINS-1:0] pin_mode_high_bits_r;       // mode field high bits
  logic [PINS-1:0] segment_function_select_r;  // pin handed to segment driver

  // bus handshake state
  port_pkg::bus_state_type           bus_state_r;    // answer sequencer
  port_pkg::bus_state_type           bus_state_nxt;  // next sequencer state
  logic                              waitrequest_r;  // registered waitrequest
  logic [port_pkg::BUS_DATA_W-1:0]   readdata_r;     // registered read data

  // pad side
  logic [PINS-1:0] pad_sync;  // pad levels after two flops

  // decoded transfer strobes
  logic bus_take;   // request seen while still stalled, answer is being built
  logic wr_commit;  // write takes effect on this edge

  // true when the byte address selects the word at a given index
  function automatic logic hit(input logic [port_pkg::BUS_ADDR_W-1:0] addr,
                               input logic [15:0] idx);
    return (addr[port_pkg::BUS_ADDR_W-1:2] == idx) && (addr[1:0] == 2'b00);
  endfunction : hit

  // byte lane extraction for write data
  function automatic logic [7:0] lane(input logic [port_pkg::BUS_DATA_W-1:0] wd,
                                      input int lsb);
    return wd[lsb +: 8];
  endfunction : lane

  // external pad levels are asynchronous to sys_clk
  pin_sync #(
    .WIDTH (PINS)
  ) u_pin_sync (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .async_in (pad_in),
    .sync_out (pad_sync)
  );

  // registered drive decode keeps every pad control straight from a flop
  pin_drive #(
    .WIDTH (PINS)
  ) u_pin_drive (
    .sys_clk      (sys_clk),
    .reset        (reset),
    .dir          (pin_direction_select_r),
    .mode_low     (pin_mode_low_bits_r),
    .mode_high    (pin_mode_high_bits_r),
    .level        (pin_level_data_r),
    .seg_sel      (segment_function_select_r),
    .seg_level    (seg_drive),
    .pad_out      (pad_out),
    .pad_oe       (pad_oe),
    .pull_up_en   (pull_up_en),
    .pull_down_en (pull_down_en)
  );

  // a request is taken on the first edge where it is seen; one cycle later
  // waitrequest falls and the master completes, so every access is two cycles
  assign bus_take  = (avs_read || avs_write) && (bus_state_r == port_pkg::BUS_IDLE);
  assign wr_commit = avs_write && (bus_state_r == port_pkg::BUS_ANSWER);

  // answer sequencer next state
  always_comb begin
    bus_state_nxt = bus_state_r;
    case (bus_state_r)
      port_pkg::BUS_IDLE: begin
        if (bus_take) begin
          bus_state_nxt = port_pkg::BUS_ANSWER;
        end
      end
      port_pkg::BUS_ANSWER: begin
        // the master must release on this edge, so always return to idle
        bus_state_nxt = port_pkg::BUS_IDLE;
      end
      default: begin
        bus_state_nxt = port_pkg::BUS_IDLE;
      end
    endcase
  end

  // sequencer state and waitrequest flop
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      bus_state_r   <= port_pkg::BUS_IDLE;
      waitrequest_r <= 1'b1;
    end else begin
      bus_state_r   <= bus_state_nxt;
      waitrequest_r <= (bus_state_nxt != port_pkg::BUS_ANSWER);
    end
  end

  // direction register
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pin_direction_select_r <= port_pkg::RESET_PIN_DIRECTION_SELECT;
    end else if (wr_commit && avs_byteenable[port_pkg::BE_LOW_BYTE]
                 && hit(avs_address, port_pkg::IDX_PIN_DIRECTION_SELECT)) begin
      pin_direction_select_r <= lane(avs_writedata, port_pkg::FIELD_BYTE0_LSB);
    end
  end

  // mode low bits: reachable by byte, or as the low half of the halfword
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pin_mode_low_bits_r <= port_pkg::RESET_PIN_MODE_LOW_BITS;
    end else if (wr_commit && avs_byteenable[port_pkg::BE_LOW_BYTE]
                 && hit(avs_address, port_pkg::IDX_PIN_MODE_LOW_BITS)) begin
      pin_mode_low_bits_r <= lane(avs_writedata, port_pkg::FIELD_BYTE0_LSB);
    end
  end

  // mode high bits: own byte address, or high lane of the halfword at ctrl0
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pin_mode_high_bits_r <= port_pkg::RESET_PIN_MODE_HIGH_BITS;
    end else if (wr_commit && avs_byteenable[port_pkg::BE_HIGH_BYTE]
                 && hit(avs_address, port_pkg::IDX_PIN_MODE_LOW_BITS)) begin
      pin_mode_high_bits_r <= lane(avs_writedata, port_pkg::FIELD_BYTE1_LSB);
    end else if (wr_commit && avs_byteenable[port_pkg::BE_LOW_BYTE]
                 && hit(avs_address, port_pkg::IDX_PIN_MODE_HIGH_BITS)) begin
      pin_mode_high_bits_r <= lane(avs_writedata, port_pkg::FIELD_BYTE0_LSB);
    end
  end

  // data register: writes always land, even on input pins, so a later
  // switch to output drives the value written beforehand
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pin_level_data_r <= port_pkg::RESET_PIN_LEVEL_DATA;
    end else if (wr_commit && avs_byteenable[port_pkg::BE_LOW_BYTE]
                 && hit(avs_address, port_pkg::IDX_PIN_LEVEL_DATA)) begin
      pin_level_data_r <= lane(avs_writedata, port_pkg::FIELD_BYTE0_LSB);
    end
  end

  // segment function select
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      segment_function_select_r <= port_pkg::RESET_SEGMENT_FUNCTION_SEL;
    end else if (wr_commit && avs_byteenable[port_pkg::BE_LOW_BYTE]
                 && hit(avs_address, port_pkg::IDX_SEGMENT_FUNCTION_SEL)) begin
      segment_function_select_r <= lane(avs_writedata, port_pkg::FIELD_BYTE0_LSB);
    end
  end

  // read data is captured at the take edge and held through the answer;
  // unmapped addresses read as zero, upper lanes are zero except the second byte of the halfword view at ctrl0
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      readdata_r <= '0;
    end else if (bus_take && avs_read) begin
      if (hit(avs_address, port_pkg::IDX_PIN_LEVEL_DATA)) begin
        // input pins show the pad, output pins the stored value
        readdata_r <= {24'h000000, (pad_sync & pin_direction_select_r)
                       | (pin_level_data_r & ~pin_direction_select_r)};
      end else if (hit(avs_address, port_pkg::IDX_PIN_DIRECTION_SELECT)) begin
        readdata_r <= {24'h000000, pin_direction_select_r};
      end else if (hit(avs_address, port_pkg::IDX_PIN_MODE_LOW_BITS)) begin
        // halfword view: both control bytes side by side
        readdata_r <= {16'h0000, pin_mode_high_bits_r, pin_mode_low_bits_r};
      end else if (hit(avs_address, port_pkg::IDX_PIN_MODE_HIGH_BITS)) begin
        readdata_r <= {24'h000000, pin_mode_high_bits_r};
      end else if (hit(avs_address, port_pkg::IDX_SEGMENT_FUNCTION_SEL)) begin
        readdata_r <= {24'h000000, segment_function_select_r};
      end else begin
        readdata_r <= '0;  // unmapped
      end
    end
  end

  assign avs_readdata    = readdata_r;
  assign avs_waitrequest = waitrequest_r;

  // ---------------- checks ----------------

  // a request is answered exactly one cycle after it is taken
  chk_wait_one_cycle: assert property (
    @(posedge sys_clk) disable iff (reset)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest did not answer in one cycle");

  // direction write shows up in the register the edge after commit
  chk_dir_write_back: assert property (
    @(posedge sys_clk) disable iff (reset)
    avs_write && !avs_waitrequest && avs_byteenable[0]
      && hit(avs_address, port_pkg::IDX_PIN_DIRECTION_SELECT)
    |=> pin_direction_select_r == $past(avs_writedata[7:0]))
    else $error("direction register did not take written value");

  // halfword write at ctrl0 updates the high control byte too
  chk_halfword_high: assert property (
    @(posedge sys_clk) disable iff (reset)
    avs_write && !avs_waitrequest && avs_byteenable[1]
      && hit(avs_address, port_pkg::IDX_PIN_MODE_LOW_BITS)
    |=> pin_mode_high_bits_r == $past(avs_writedata[15:8]))
    else $error("halfword write missed high control byte");

  // input pins of the port function are never driven
  chk_input_undriven: assert property (
    @(posedge sys_clk) disable iff (reset)
    ##1 ((pad_oe & $past(pin_direction_select_r) & ~$past(segment_function_select_r))
         == '0))
    else $error("input pin is being driven");

  // no pull resistor on an output pin, never both pulls at once
  chk_pull_inputs_only: assert property (
    @(posedge sys_clk) disable iff (reset)
    ##1 ((((pull_up_en | pull_down_en) & ~$past(pin_direction_select_r)) == '0)
         && ((pull_up_en & pull_down_en) == '0)))
    else $error("pull enabled on output pin or both pulls on");

  // n-channel open drain never sources a high level
  chk_nch_sinks_only: assert property (
    @(posedge sys_clk) disable iff (reset)
    ##1 ((pad_out & pad_oe & $past(~pin_mode_low_bits_r & pin_mode_high_bits_r
          & ~pin_direction_select_r & ~segment_function_select_r)) == '0))
    else $error("n-channel drain pin drove high");

  // p-channel open drain never sinks a low level
  chk_pch_sources_only: assert property (
    @(posedge sys_clk) disable iff (reset)
    ##1 ((~pad_out & pad_oe & $past(pin_mode_low_bits_r & ~pin_mode_high_bits_r
          & ~pin_direction_select_r & ~segment_function_select_r)) == '0))
    else $error("p-channel drain pin drove low");

  // push-pull output pins carry the data register level one edge later
  chk_push_pull_level: assert property (
    @(posedge sys_clk) disable iff (reset)
    ##1 (((pad_out ^ $past(pin_level_data_r)) & $past(pin_mode_low_bits_r
          & pin_mode_high_bits_r & ~pin_direction_select_r
          & ~segment_function_select_r)) == '0))
    else $error("push-pull pin level differs from data register");

  // data read returns pad level on inputs, stored level on outputs
  chk_data_read_mix: assert property (
    @(posedge sys_clk) disable iff (reset)
    avs_read && avs_waitrequest && hit(avs_address, port_pkg::IDX_PIN_LEVEL_DATA)
    |=> avs_readdata[7:0] == (($past(pad_sync) & $past(pin_direction_select_r))
        | ($past(pin_level_data_r) & ~$past(pin_direction_select_r))))
    else $error("data read returned wrong mix");

  // segment pins are always driven with the segment level
  chk_segment_drive: assert property (
    @(posedge sys_clk) disable iff (reset)
    ##1 ((((~pad_oe) | (pad_out ^ $past(seg_drive))) & $past(segment_function_select_r))
         == '0))
    else $error("segment pin not following segment driver");

  // byte or halfword write at ctrl0 lands in the mode low bits
  chk_mode_low_write: assert property (
    @(posedge sys_clk) disable iff (reset)
    avs_write && !avs_waitrequest && avs_byteenable[0]
      && hit(avs_address, port_pkg::IDX_PIN_MODE_LOW_BITS)
    |=> pin_mode_low_bits_r == $past(avs_writedata[7:0]))
    else $error("mode low bits did not take written value");

  // byte write at ctrl1 lands in the mode high bits
  chk_mode_high_write: assert property (
    @(posedge sys_clk) disable iff (reset)
    avs_write && !avs_waitrequest && avs_byteenable[0]
      && hit(avs_address, port_pkg::IDX_PIN_MODE_HIGH_BITS)
    |=> pin_mode_high_bits_r == $past(avs_writedata[7:0]))
    else $error("mode high bits did not take written value");

  // data writes land whatever the pin directions are
  chk_data_write_back: assert property (
    @(posedge sys_clk) disable iff (reset)
    avs_write && !avs_waitrequest && avs_byteenable[0]
      && hit(avs_address, port_pkg::IDX_PIN_LEVEL_DATA)
    |=> pin_level_data_r == $past(avs_writedata[7:0]))
    else $error("data register did not take written value");

  // high-impedance output pins neither drive nor pull
  chk_hiz_output_quiet: assert property (
    @(posedge sys_clk) disable iff (reset)
    ##1 (((pad_oe | pull_up_en | pull_down_en) & $past(~pin_mode_low_bits_r
          & ~pin_mode_high_bits_r & ~pin_direction_select_r
          & ~segment_function_select_r)) == '0))
    else $error("high-impedance output pin driven or pulled");

endmodule : eight_bit_bidir_port

// >>> rtl/pin_drive.sv
// per-pin drive and pull decode, registered so the pad controls are glitch free
`timescale 1ns/1ps
module pin_drive #(
  parameter int WIDTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] dir,
  input  wire logic [WIDTH-1:0] mode_low,
  input  wire logic [WIDTH-1:0] mode_high,
  input  wire logic [WIDTH-1:0] level,
  input  wire logic [WIDTH-1:0] seg_sel,
  input  wire logic [WIDTH-1:0] seg_level,
  output logic      [WIDTH-1:0] pad_out,
  output logic      [WIDTH-1:0] pad_oe,
  output logic      [WIDTH-1:0] pull_up_en,
  output logic      [WIDTH-1:0] pull_down_en
);

  // decode one pin into {out, oe, pull_up, pull_down}
  function automatic logic [3:0] decode_pin(input logic d, input logic [1:0] mode,
                                            input logic lvl);
    logic [3:0] r;
    r = 4'h0;
    if (d == port_pkg::DIR_OUTPUT) begin
      case (mode)
        port_pkg::MODE_PCH_DRAIN: r = {1'b1, lvl, 2'b00};   // only sources high
        port_pkg::MODE_NCH_DRAIN: r = {1'b0, ~lvl, 2'b00};  // only sinks low
        port_pkg::MODE_PUSH_PULL: r = {lvl, 1'b1, 2'b00};
        default:                  r = 4'h0;                 // high impedance
      endcase
    end else begin
      case (mode)
        port_pkg::MODE_PCH_DRAIN: r = 4'h1;  // pull-down
        port_pkg::MODE_NCH_DRAIN: r = 4'h2;  // pull-up
        default:                  r = 4'h0;  // floating input
      endcase
    end
    return r;
  endfunction : decode_pin

  // one register stage: new settings reach the pad the edge after the write
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pad_out      <= '0;
      pad_oe       <= '0;
      pull_up_en   <= '0;
      pull_down_en <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (seg_sel[i]) begin
          // segment driver owns the pin, driven hard both ways
          pad_out[i]      <= seg_level[i];
          pad_oe[i]       <= 1'b1;
          pull_up_en[i]   <= 1'b0;
          pull_down_en[i] <= 1'b0;
        end else begin
          {pad_out[i], pad_oe[i], pull_up_en[i], pull_down_en[i]}
            <= decode_pin(dir[i], {mode_high[i], mode_low[i]}, level[i]);
        end
      end
    end
  end

endmodule : pin_drive

// >>> rtl/pin_sync.sv
// two-flop synchroniser for the asynchronous pad levels
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;  // first stage, read only by the second stage

  // two stages so that a metastable first stage settles before use
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : pin_sync

// >>> rtl/port_pkg.sv
// shared constants and types for the eight-bit bidirectional port
package port_pkg;

  // port geometry
  localparam int PIN_COUNT = 8;
  localparam int BUS_ADDR_W = 18;
  localparam int BUS_DATA_W = 32;

  // register indices; the byte address on the bus is four times the index
  localparam logic [15:0] IDX_PIN_LEVEL_DATA       = 16'hf260;
  localparam logic [15:0] IDX_PIN_DIRECTION_SELECT = 16'hf261;
  localparam logic [15:0] IDX_PIN_MODE_LOW_BITS    = 16'hf262;
  localparam logic [15:0] IDX_PIN_MODE_HIGH_BITS   = 16'hf263;
  localparam logic [15:0] IDX_SEGMENT_FUNCTION_SEL = 16'hf264;

  // field positions inside a bus word
  localparam int FIELD_BYTE0_LSB = 0;
  localparam int FIELD_BYTE1_LSB = 8;
  localparam int BE_LOW_BYTE     = 0;
  localparam int BE_HIGH_BYTE    = 1;

  // reset values
  localparam logic [7:0] RESET_PIN_LEVEL_DATA       = 8'h00;
  localparam logic [7:0] RESET_PIN_DIRECTION_SELECT = 8'h00;
  localparam logic [7:0] RESET_PIN_MODE_LOW_BITS    = 8'h00;
  localparam logic [7:0] RESET_PIN_MODE_HIGH_BITS   = 8'h00;
  localparam logic [7:0] RESET_SEGMENT_FUNCTION_SEL = 8'h00;

  // direction bit meaning
  localparam logic DIR_OUTPUT = 1'b0;
  localparam logic DIR_INPUT  = 1'b1;

  // two-bit mode field {high, low}
  localparam logic [1:0] MODE_HIZ       = 2'b00;
  localparam logic [1:0] MODE_PCH_DRAIN = 2'b01;
  localparam logic [1:0] MODE_NCH_DRAIN = 2'b10;
  localparam logic [1:0] MODE_PUSH_PULL = 2'b11;

  // bus answer sequencer states, one-hot
  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b01,
    BUS_ANSWER = 2'b10
  } bus_state_type;

endpackage : port_pkg

// >>> tb/eight_bit_bidir_port_tb.sv
// self-checking bench for the eight-bit bidirectional port
`timescale 1ns/1ps
module eight_bit_bidir_port_tb;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic [17:0] avs_address = 18'h00000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [7:0]  pad_in, seg_drive = 8'h00, pad_out, pad_oe, pull_up_en, pull_down_en;
  logic [7:0]  ext_en = 8'h00, ext_val = 8'h00; // external driver of the pads
  logic [31:0] q;                               // last read data
  logic [31:0] pads;                            // all pad controls in one word
  int          error_cnt = 0;
  int          checks_done = 0;

  // 250 MHz system clock
  always #2 sys_clk = ~sys_clk;

  // pulls and drive packed the way pad_exp returns them
  assign pads = {pull_down_en, pull_up_en, pad_oe, pad_out};

  eight_bit_bidir_port DUT (.sys_clk(sys_clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pad_in(pad_in), .seg_drive(seg_drive),
    .pad_out(pad_out), .pad_oe(pad_oe), .pull_up_en(pull_up_en),
    .pull_down_en(pull_down_en));

  pin_partner partner (.sys_clk(sys_clk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .ext_en(ext_en),
    .ext_val(ext_val), .pad_level(pad_in));

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  // one avalon access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [15:0] d,
                     input logic [3:0] be);
    int n;
    @(posedge sys_clk);
    avs_address    <= {idx, 2'b00};
    avs_write      <= wr;
    avs_read       <= ~wr;
    avs_writedata  <= {16'h0000, d};
    avs_byteenable <= be;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) check(32'hdead, 32'h0); // hung access counts as a mismatch
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  // byte write shorthand
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    bus(1'b1, idx, {8'h00, d}, 4'h1);
  endtask : wr

  // program direction, both mode bytes and data, then let the pads settle
  task automatic setup(input logic [7:0] dir, c0, c1, d);
    wr(port_pkg::IDX_PIN_DIRECTION_SELECT, dir);
    wr(port_pkg::IDX_PIN_MODE_LOW_BITS, c0);
    wr(port_pkg::IDX_PIN_MODE_HIGH_BITS, c1);
    wr(port_pkg::IDX_PIN_LEVEL_DATA, d);
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : setup

  // expected pad controls per pin, pad_out and pad_oe expected low on input pins
  function automatic logic [31:0] pad_exp(input logic [7:0] dir, c0, c1, d);
    logic [7:0] oe = 8'h00, o = 8'h00, pu = 8'h00, pd = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (dir[i]) begin
        pd[i] = ({c1[i], c0[i]} == 2'b01);
        pu[i] = ({c1[i], c0[i]} == 2'b10);
      end else begin
        oe[i] = (c1[i] & c0[i]) | (~c1[i] & c0[i] & d[i]) | (c1[i] & ~c0[i] & ~d[i]);
        o[i]  = (c0[i] & ~c1[i]) | (c1[i] & c0[i] & d[i]);
      end
    end
    return {pd, pu, oe, o};
  endfunction : pad_exp

  // reset state of the data, direction and both mode registers, and of the pads
  task automatic t_reset();
    for (int r = 0; r < 4; r++) begin
      bus(1'b0, 16'hf260 + 16'(r), 16'h0000, 4'h1);
      check(q, 32'h0);
    end
    check({pull_down_en, pull_up_en, pad_oe, pad_out}, 32'h0);
    $display("test reset done, errors %0d", error_cnt);
  endtask : t_reset

  // readback, disabled lane, unmapped address, halfword pairing
  task automatic t_regs();
    wr(port_pkg::IDX_PIN_DIRECTION_SELECT, 8'ha5);
    bus(1'b1, port_pkg::IDX_PIN_DIRECTION_SELECT, 16'h0011, 4'h0);
    bus(1'b0, port_pkg::IDX_PIN_DIRECTION_SELECT, 16'h0000, 4'h1);
    check(q, 32'ha5);
    wr(16'hf270, 8'h55);
    bus(1'b0, 16'hf270, 16'h0000, 4'h1);
    check(q, 32'h0);
    bus(1'b1, port_pkg::IDX_PIN_MODE_LOW_BITS, 16'h5aa5, 4'h3);
    bus(1'b0, port_pkg::IDX_PIN_MODE_LOW_BITS, 16'h0000, 4'h1);
    check(q[7:0], 8'ha5);
    bus(1'b0, port_pkg::IDX_PIN_MODE_HIGH_BITS, 16'h0000, 4'h1);
    check(q[7:0], 8'h5a);
    bus(1'b0, port_pkg::IDX_PIN_MODE_LOW_BITS, 16'h0000, 4'h3);
    check(q[15:0], 16'h5aa5);
    $display("test registers done, errors %0d", error_cnt);
  endtask : t_regs

  // every output drive style, pins given different modes to expose bit mapping
  task automatic t_out();
    logic [7:0] pats[2] = '{8'haa, 8'hcc};
    logic [7:0] dv[2] = '{8'h5c, 8'ha3};
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 2; k++) begin
        setup(8'h00, pats[p], pats[1-p], dv[k]);
        check(pads, pad_exp(8'h00, pats[p], pats[1-p], dv[k]));
        bus(1'b0, port_pkg::IDX_PIN_LEVEL_DATA, 16'h0000, 4'h1);
        check(q, {24'h0, dv[k]});
      end
    end
    $display("test output modes done, errors %0d", error_cnt);
  endtask : t_out

  // input modes, pad level readback, pulls seen on the wire, mixed direction
  task automatic t_in();
    ext_en  <= 8'hff;
    ext_val <= 8'h69;
    setup(8'hff, 8'haa, 8'hcc, 8'h00);
    check(pads[31:8], pad_exp(8'hff, 8'haa, 8'hcc, 8'h00) >> 8);
    bus(1'b0, port_pkg::IDX_PIN_LEVEL_DATA, 16'h0000, 4'h1);
    check(q, 32'h69);
    ext_en <= 8'h00;
    setup(8'hff, 8'h00, 8'hff, 8'h00);
    bus(1'b0, port_pkg::IDX_PIN_LEVEL_DATA, 16'h0000, 4'h1);
    check(q, 32'hff);
    setup(8'hff, 8'hff, 8'h00, 8'h00);
    bus(1'b0, port_pkg::IDX_PIN_LEVEL_DATA, 16'h0000, 4'h1);
    check(q, 32'h00);
    ext_en  <= 8'hf0;
    ext_val <= 8'h96;
    setup(8'hf0, 8'hff, 8'hff, 8'h33);
    bus(1'b0, port_pkg::IDX_PIN_LEVEL_DATA, 16'h0000, 4'h1);
    check(q, 32'h93);
    ext_en <= 8'h00;
    $display("test input modes done, errors %0d", error_cnt);
  endtask : t_in

  // segment select hands pins to the segment driver and back
  task automatic t_seg();
    seg_drive <= 8'h80;
    wr(port_pkg::IDX_SEGMENT_FUNCTION_SEL, 8'h81);
    setup(8'h00, 8'h00, 8'h00, 8'h00);
    check({pull_down_en, pull_up_en, pad_oe, pad_out}, 32'h00008180);
    wr(port_pkg::IDX_SEGMENT_FUNCTION_SEL, 8'h00);
    setup(8'h00, 8'h00, 8'h00, 8'h00);
    check({pad_oe, pad_out}, 16'h0000);
    $display("test segment done, errors %0d", error_cnt);
  endtask : t_seg

  // verdict and end of run
  task automatic conclude();
    $display("checks %0d, errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude

  // main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset();
    t_regs();
    t_out();
    t_in();
    t_seg();
    conclude();
  end

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #40000;
    error_cnt++;
    conclude();
  end
endmodule : eight_bit_bidir_port_tb

// >>> tb/pin_partner.sv
// model of the circuitry wired to the eight port pads
`timescale 1ns/1ps
module pin_partner (
  input  wire logic       sys_clk,
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  input  wire logic [7:0] pull_up_en,
  input  wire logic [7:0] pull_down_en,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pad_level
);
  logic [7:0] float_r; // undriven pads wander; no silent zero
  // floating pattern changes every cycle so a read of it never looks stable
  always_ff @(posedge sys_clk) begin
    float_r <= (float_r === 8'hxx) ? 8'h5a : ~float_r;
  end
  // port drive wins, then external driver, then pulls, else floating
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_oe[i]) pad_level[i] = pad_out[i];
      else if (ext_en[i]) pad_level[i] = ext_val[i];
      else if (pull_up_en[i]) pad_level[i] = 1'b1;
      else if (pull_down_en[i]) pad_level[i] = 1'b0;
      else pad_level[i] = float_r[i];
    end
  end
endmodule : pin_partner
